//--- readback_pkg.sv
package readback_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_IDENTITY_AND_STATUS = 8'h40;
   localparam logic [7:0] ADDR_PIN_LEVEL_READBACK  = 8'h41;
   localparam logic [7:0] ADDR_RATIO_BYTE0         = 8'h42;
   localparam logic [7:0] ADDR_RATIO_BYTE3         = 8'h45;
   localparam logic [7:0] ADDR_STATUS_BYTE0        = 8'h46;
   localparam logic [7:0] ADDR_STATUS_BYTE23       = 8'h5D;

   // -----------------------------------------------------------------
   // Field layouts and reset values
   // -----------------------------------------------------------------
   localparam int         PART_ID_WIDTH   = 6;
   localparam int         PIN_COUNT       = 4;
   localparam int         RATIO_WIDTH     = 32;
   localparam int         STATUS_WIDTH    = 192;
   localparam logic [3:0] PIN_UPPER_ZERO  = 4'h0;
   localparam logic [31:0] RATIO_RESET    = 32'h0000_0000;
   localparam logic [191:0] STATUS_RESET  = 192'h0;
   localparam logic [7:0] UNMAPPED_BYTE   = 8'h00;

   // -----------------------------------------------------------------
   // Serial control bus framing
   // -----------------------------------------------------------------
   localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
   localparam logic [6:0] DEFAULT_BUS_ADDR = 7'h48;

   typedef enum logic [8:0] {
      ST_IDLE      = 9'b000000001,
      ST_ADDR      = 9'b000000010,
      ST_ADDR_ACK  = 9'b000000100,
      ST_PTR       = 9'b000001000,
      ST_PTR_ACK   = 9'b000010000,
      ST_WDATA     = 9'b000100000,
      ST_WDATA_ACK = 9'b001000000,
      ST_RDATA     = 9'b010000000,
      ST_RDATA_ACK = 9'b100000000
   } bus_state_e;

endpackage

//--- level_sync.sv
`timescale 1ns/1ns
`default_nettype none

module level_sync
   import readback_pkg::*;
#(
   parameter int          WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // -----------------------------------------------------------------
   // Two-stage synchroniser; first stage feeds only the second
   // -----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;

endmodule

`default_nettype wire

//--- status_readback_regs.sv
// Operation
// R01: Identity register bits 7:2 always return the same fixed part identifier.
// R02: Bit 1 shows the automute condition, one while active.
// R03: In slave timing, bit 0 is high only while the rate loop is locked.
// R04: Bit 0 forced high as timing master or fixed-ratio or oscillator mode.
// R05: Pin readback bits 3:0 show pins four..one, upper four bits zero.
// R06: Clock ratio word presents sample-to-master clock ratio, zero after reset.
// R07: Reading ratio low byte snapshots all 32 bits for upper byte reads.
// R08: Host reads ratio low byte first, then the three upper bytes.
// R09: Host computes sample rate as ratio times master clock over 2^32.
// R10: 192-bit input status field, zero after reset, channel-status or user bits.
// R11: Readback registers are read-only; writes change nothing.
// R12: Mute and lock flags are live, not sticky; reads alter nothing.
`timescale 1ns/1ns
`default_nettype none

module status_readback_regs
   import readback_pkg::*;
#(
   // Arbitrary neutral identifier value
   parameter logic [PART_ID_WIDTH-1:0] PART_IDENTIFIER = 6'h11,
   parameter logic [6:0]               BUS_ADDR        = DEFAULT_BUS_ADDR
) (
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_rst,
   // Serial control bus pins
   input  wire logic                    i_scl,
   input  wire logic                    i_sda_i,
   output logic                         o_sda_o,
   output logic                         o_sda_oe,
   // Live conditions from the audio datapath
   input  wire logic                    i_silence_mute_flag,
   input  wire logic                    i_rate_loop_locked,
   input  wire logic                    i_timing_master,
   input  wire logic                    i_fixed_ratio_clock_mode,
   input  wire logic                    i_oscillator_rate_mode,
   input  wire logic [RATIO_WIDTH-1:0]  i_clock_ratio_word,
   input  wire logic [STATUS_WIDTH-1:0] i_digital_input_status_bits,
   // General-purpose pins, asynchronous
   input  wire logic [PIN_COUNT-1:0]    i_pin_level
);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic                    scl_s;
   logic                    sda_s;
   logic [PIN_COUNT-1:0]    pin_s;
   logic                    scl_prev_q;
   logic                    sda_prev_q;
   bus_state_e              state_q;
   logic [3:0]              cnt_q;
   logic [7:0]              rx_q;
   logic [7:0]              tx_q;
   logic [7:0]              ptr_q;
   logic                    rw_q;
   logic                    nack_q;
   logic                    oe_q;
   logic [RATIO_WIDTH-1:0]  ratio_q;
   logic [RATIO_WIDTH-1:0]  ratio_hold_q;
   logic [STATUS_WIDTH-1:0] status_q;

   wire scl_rise;
   wire scl_fall;
   wire bus_start;
   wire bus_stop;
   wire byte_done;
   wire addr_match;
   wire receiving;
   wire load_read;
   wire ptr_advance;
   wire rate_lock_flag;
   wire [7:0] identity_byte;
   wire [7:0] pin_byte;
   wire [7:0] ratio_byte;
   wire [7:0] status_byte;
   wire [7:0] read_byte;
   wire [1:0] ratio_idx;
   wire [7:0] status_off;
   wire [4:0] status_idx;
   wire in_ratio;
   wire in_status;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   level_sync #(
      .WIDTH     (2),
      .RESET_VAL (2'h3)
   ) u_bus_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_async   ({i_scl, i_sda_i}),
      .o_sync    ({scl_s, sda_s})
   );

   level_sync #(
      .WIDTH     (PIN_COUNT),
      .RESET_VAL (4'h0)
   ) u_pin_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_async   (i_pin_level),
      .o_sync    (pin_s)
   );

   // -----------------------------------------------------------------
   // Bus edge and condition detection
   // -----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_prev_q;
   assign scl_fall  = ~scl_s & scl_prev_q;
   assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
   assign byte_done = scl_fall & (cnt_q == BITS_PER_BYTE);
   assign addr_match = (rx_q[7:1] == BUS_ADDR);
   assign receiving = (state_q == ST_ADDR) | (state_q == ST_PTR) |
                      (state_q == ST_WDATA);
   assign load_read = scl_fall &
                      (((state_q == ST_ADDR_ACK) & rw_q) |
                       ((state_q == ST_RDATA_ACK) & ~nack_q));
   assign ptr_advance = byte_done &
                        ((state_q == ST_RDATA) | (state_q == ST_WDATA));

   // -----------------------------------------------------------------
   // Bus sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= ST_IDLE;
      end else if (bus_start) begin
         state_q <= ST_ADDR;
      end else if (bus_stop) begin
         state_q <= ST_IDLE;
      end else if (scl_fall) begin
         unique case (state_q)
            ST_IDLE: begin
               state_q <= ST_IDLE;
            end
            ST_ADDR: begin
               if (byte_done) begin
                  state_q <= addr_match ? ST_ADDR_ACK : ST_IDLE;
               end
            end
            ST_ADDR_ACK: begin
               state_q <= rw_q ? ST_RDATA : ST_PTR;
            end
            ST_PTR: begin
               if (byte_done) begin
                  state_q <= ST_PTR_ACK;
               end
            end
            ST_PTR_ACK: begin
               state_q <= ST_WDATA;
            end
            ST_WDATA: begin
               if (byte_done) begin
                  state_q <= ST_WDATA_ACK;
               end
            end
            ST_WDATA_ACK: begin
               state_q <= ST_WDATA;
            end
            ST_RDATA: begin
               if (byte_done) begin
                  state_q <= ST_RDATA_ACK;
               end
            end
            ST_RDATA_ACK: begin
               state_q <= nack_q ? ST_IDLE : ST_RDATA;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Bit counter, restarted at every byte boundary
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= 4'h0;
      end else if (bus_start | (scl_fall & (cnt_q == BITS_PER_BYTE))) begin
         cnt_q <= 4'h0;
      end else if (scl_rise & (receiving | (state_q == ST_RDATA))) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   // Receive shifter; data bytes are shifted in and then dropped
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_q <= 8'h00;
      end else if (scl_rise & receiving) begin
         rx_q <= {rx_q[6:0], sda_s};
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         rw_q <= 1'b0;
      end else if (byte_done & (state_q == ST_ADDR)) begin
         rw_q <= rx_q[0];
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         nack_q <= 1'b0;
      end else if (scl_rise & (state_q == ST_RDATA_ACK)) begin
         nack_q <= sda_s;
      end
   end

   // Register pointer: set by the pointer byte, steps after each data byte
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ptr_q <= 8'h00;
      end else if (byte_done & (state_q == ST_PTR)) begin
         ptr_q <= rx_q;
      end else if (ptr_advance) begin
         ptr_q <= ptr_q + 8'h01;
      end
   end

   // -----------------------------------------------------------------
   // Data line drive, open drain: only ever pulls low
   // -----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_q <= 8'h00;
         oe_q <= 1'b0;
      end else if (bus_start | bus_stop) begin
         oe_q <= 1'b0;
      end else if (load_read) begin
         tx_q <= read_byte;
         oe_q <= ~read_byte[7];
      end else if (scl_fall & (state_q == ST_RDATA) & ~byte_done) begin
         tx_q <= {tx_q[6:0], 1'b0};
         oe_q <= ~tx_q[6];
      end else if (byte_done & (state_q != ST_RDATA)) begin
         oe_q <= (state_q != ST_ADDR) | addr_match;
      end else if (scl_fall) begin
         oe_q <= 1'b0;
      end
   end

   assign o_sda_o  = 1'b0;
   assign o_sda_oe = oe_q;

   // -----------------------------------------------------------------
   // Captured datapath values
   // -----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ratio_q <= RATIO_RESET; // R06
      end else begin
         ratio_q <= i_clock_ratio_word; // R06
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ratio_hold_q <= RATIO_RESET;
      end else if (load_read & (ptr_q == ADDR_RATIO_BYTE0)) begin
         ratio_hold_q <= ratio_q; // R07
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         status_q <= STATUS_RESET; // R10
      end else begin
         status_q <= i_digital_input_status_bits; // R10
      end
   end

   // -----------------------------------------------------------------
   // Read selection; nothing here is writable
   // -----------------------------------------------------------------
   assign rate_lock_flag = i_timing_master | i_fixed_ratio_clock_mode |
                           i_oscillator_rate_mode |  // R04
                           i_rate_loop_locked;       // R03
   assign identity_byte = {PART_IDENTIFIER,           // R01
                           i_silence_mute_flag,       // R02 R12
                           rate_lock_flag};           // R12
   assign pin_byte      = {PIN_UPPER_ZERO, pin_s};    // R05
   assign in_ratio      = (ptr_q >= ADDR_RATIO_BYTE0) &
                          (ptr_q <= ADDR_RATIO_BYTE3);
   assign in_status     = (ptr_q >= ADDR_STATUS_BYTE0) &
                          (ptr_q <= ADDR_STATUS_BYTE23);
   assign ratio_idx     = 2'(ptr_q - ADDR_RATIO_BYTE0);
   assign status_off    = ptr_q - ADDR_STATUS_BYTE0;
   assign status_idx    = status_off[4:0];
   // Low byte is live; upper bytes come from the snapshot
   assign ratio_byte    = (ratio_idx == 2'h0) ? ratio_q[7:0] :
                          ratio_hold_q[8*ratio_idx +: 8]; // R07
   assign status_byte   = status_q[8*status_idx +: 8];    // R10
   assign read_byte     =
      (ptr_q == ADDR_IDENTITY_AND_STATUS) ? identity_byte :
      (ptr_q == ADDR_PIN_LEVEL_READBACK)  ? pin_byte      :
      in_ratio                            ? ratio_byte    :
      in_status                           ? status_byte   :
                                            UNMAPPED_BYTE; // R11

endmodule

`default_nettype wire

//--- status_readback_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none

module status_readback_regs_checker
   import readback_pkg::*;
#(
   parameter logic [PART_ID_WIDTH-1:0] PART_IDENTIFIER = 6'h11
) (
   input wire logic                    i_ref_clk,
   input wire logic                    i_rst,
   input wire logic                    i_scl,
   input wire logic                    i_sda_i,
   input wire logic                    i_silence_mute_flag,
   input wire logic                    i_rate_loop_locked,
   input wire logic                    i_timing_master,
   input wire logic                    i_fixed_ratio_clock_mode,
   input wire logic                    i_oscillator_rate_mode,
   input wire logic [RATIO_WIDTH-1:0]  i_clock_ratio_word,
   input wire logic [STATUS_WIDTH-1:0] i_digital_input_status_bits,
   input wire logic [PIN_COUNT-1:0]    i_pin_level
);
   // ------------------------------------------------------------
   // Bus monitor: direction, pointer and byte position on the wire
   // ------------------------------------------------------------
   logic       scl_q, sda_q, dir_q, rise, start, fin, forced;
   logic [3:0] bit_q;
   logic [4:0] byte_q;
   logic [7:0] ptr_q, sh_q, addr, data;

   assign rise   = !scl_q && i_scl;
   assign start  = scl_q && i_scl && sda_q && !i_sda_i;
   assign data   = {sh_q[6:0], i_sda_i};
   assign addr   = ptr_q + 8'(byte_q) - 8'h01;
   assign fin    = rise && bit_q == 4'h7 && dir_q && byte_q != 5'h00;
   assign forced = i_timing_master || i_fixed_ratio_clock_mode
                   || i_oscillator_rate_mode;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
         dir_q  <= 1'b0;
         bit_q  <= 4'h0;
         byte_q <= 5'h00;
         ptr_q  <= 8'h00;
         sh_q   <= 8'h00;
      end else begin
         scl_q <= i_scl;
         sda_q <= i_sda_i;
         if (start) begin
            bit_q  <= 4'h0;
            byte_q <= 5'h00;
         end else if (rise) begin
            sh_q  <= data;
            bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
            if (bit_q == 4'h8) byte_q <= byte_q + 5'h01;
            if (bit_q == 4'h7 && byte_q == 5'h00) dir_q <= i_sda_i;
            if (bit_q == 4'h7 && byte_q == 5'h01 && !dir_q) ptr_q <= data;
         end
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   a_id_fixed: assert property (
      fin && addr == ADDR_IDENTITY_AND_STATUS |-> data[7:2] == PART_IDENTIFIER)
      else $error("part identifier field wrong");
   a_mute_live: assert property (
      fin && addr == ADDR_IDENTITY_AND_STATUS |-> data[1] == i_silence_mute_flag)
      else $error("mute flag does not follow its input");
   a_lock_slave: assert property (
      fin && addr == ADDR_IDENTITY_AND_STATUS && !forced
      |-> data[0] == i_rate_loop_locked)
      else $error("lock flag does not follow the loop");
   a_lock_forced: assert property (
      fin && addr == ADDR_IDENTITY_AND_STATUS && forced |-> data[0])
      else $error("lock flag not forced high");
   a_pin_levels: assert property (
      fin && addr == ADDR_PIN_LEVEL_READBACK |-> data == {4'h0, i_pin_level})
      else $error("pin readback byte wrong");
   a_ratio_low: assert property (
      fin && addr == ADDR_RATIO_BYTE0 |-> data == i_clock_ratio_word[7:0])
      else $error("ratio low byte wrong");
   a_status_bytes: assert property (
      fin && addr >= ADDR_STATUS_BYTE0 && addr <= ADDR_STATUS_BYTE23
      |-> data == i_digital_input_status_bits[8*(addr-ADDR_STATUS_BYTE0) +: 8])
      else $error("status byte wrong");
   a_write_acked: assert property (
      rise && bit_q == 4'h8 && !dir_q |-> !i_sda_i)
      else $error("written byte not acknowledged");
endmodule

bind status_readback_regs status_readback_regs_checker #(
   .PART_IDENTIFIER(PART_IDENTIFIER)
) status_readback_regs_checker_inst (
   .i_ref_clk, .i_rst, .i_scl, .i_sda_i, .i_silence_mute_flag,
   .i_rate_loop_locked, .i_timing_master, .i_fixed_ratio_clock_mode,
   .i_oscillator_rate_mode, .i_clock_ratio_word,
   .i_digital_input_status_bits, .i_pin_level
);

`default_nettype wire

//--- host_model.sv
`timescale 1ns/1ns
`default_nettype none

module host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h48
) (
   input  wire logic i_ref_clk,
   input  wire logic i_sda_line,
   output var logic  o_scl,
   output var logic  o_sda_pull
);
   // ------------------------------------------------------------
   // Bus master: data changes only while the bus clock is low, except in start and stop
   // ------------------------------------------------------------
   logic [7:0] rbuf [0:31];
   logic       nack_seen;
   logic       odd;

   initial begin
      o_scl = 1'b1;
      o_sda_pull = 1'b0;
      nack_seen = 1'b0;
      odd = 1'b0;
   end

   function automatic logic [63:0] rate_of(input logic [31:0] w,
                                           input logic [31:0] mclk);
      return (64'(w) * 64'(mclk)) >> 32;
   endfunction

   task automatic gap(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask

   // Bits of 12 and 13 cycles alternate for a 125 ns average
   task automatic bit_io(input logic d, output logic q);
      o_sda_pull = !d;
      gap(5 + int'(odd));
      odd = !odd;
      o_scl = 1'b1;
      gap(6);
      q = i_sda_line;
      o_scl = 1'b0;
      gap(1);
   endtask

   task automatic start_cond();
      o_sda_pull = 1'b0;
      gap(3);
      o_scl = 1'b1;
      gap(6);
      o_sda_pull = 1'b1;
      gap(6);
      o_scl = 1'b0;
      gap(1);
   endtask

   task automatic stop_cond();
      o_sda_pull = 1'b1;
      gap(3);
      o_scl = 1'b1;
      gap(6);
      o_sda_pull = 1'b0;
      gap(6);
   endtask

   task automatic put_byte(input logic [7:0] b);
      logic q;
      for (int i = 7; i >= 0; i--) bit_io(b[i], q);
      bit_io(1'b1, q);
      nack_seen = nack_seen | q;
   endtask

   task automatic write_seq(input logic [7:0] ptr, input logic [7:0] d);
      start_cond();
      put_byte({DEV_ADDR, 1'b0});
      put_byte(ptr);
      put_byte(d);
      stop_cond();
   endtask

   task automatic read_seq(input logic [7:0] ptr, input int n);
      logic q;
      start_cond();
      put_byte({DEV_ADDR, 1'b0});
      put_byte(ptr);
      start_cond();
      put_byte({DEV_ADDR, 1'b1});
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) bit_io(1'b1, rbuf[k][i]);
         bit_io(k == n - 1, q);
      end
      stop_cond();
   endtask
endmodule

`default_nettype wire

//--- test_status_readback_regs.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
   miscompares++; $display("[ERR] %0t: got %h expected %h", $time, g, e); \
   end end

module test_status_readback_regs;
   import readback_pkg::*;
   // Arbitrary identifier value for this bench
   localparam logic [5:0] PID = 6'h15;

   logic         clk, rst, scl, pull, oe, sdo, sda;
   logic         mute, lock, mst, fix, osc;
   logic [31:0]  ratio;
   logic [191:0] stat;
   logic [3:0]   pins;
   logic [63:0]  rate;
   int           miscompares = 0;
   int           cmp_count = 0;
   int           cycles = 0;

   assign sda = !(oe || pull);

   status_readback_regs #(.PART_IDENTIFIER(PID)) status_readback_regs_inst (
      .i_ref_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda_i(sda),
      .o_sda_o(sdo), .o_sda_oe(oe), .i_silence_mute_flag(mute),
      .i_rate_loop_locked(lock), .i_timing_master(mst),
      .i_fixed_ratio_clock_mode(fix), .i_oscillator_rate_mode(osc),
      .i_clock_ratio_word(ratio), .i_digital_input_status_bits(stat),
      .i_pin_level(pins));

   host_model host_model_inst (.i_ref_clk(clk), .i_sda_line(sda),
      .o_scl(scl), .o_sda_pull(pull));

   function automatic logic [7:0] rb(input int k);
      return host_model_inst.rbuf[k];
   endfunction

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = !clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         summarize();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {mute, lock, mst, fix, osc} = 5'h00;
      ratio = 32'h89AB_CDEF;
      pins = 4'h0;
      for (int i = 0; i < 24; i++) stat[8*i +: 8] = 8'h3C ^ 8'(i * 5);
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      host_model_inst.read_seq(ADDR_RATIO_BYTE0 + 8'h01, 3);
      for (int k = 0; k < 3; k++) `CHK(rb(k), 8'h00)
      for (int k = 0; k < 32; k++) begin
         {mute, lock, mst, fix, osc} = 5'(k);
         pins = 4'(k) ^ 4'h9;
         host_model_inst.read_seq(ADDR_IDENTITY_AND_STATUS, 2);
         `CHK(rb(0), {PID, mute, lock | mst | fix | osc})
         `CHK(rb(1), {4'h0, pins})
      end
      ratio = 32'h1234_5678;
      host_model_inst.read_seq(ADDR_RATIO_BYTE0, 1);
      `CHK(rb(0), 8'h78)
      ratio = 32'hFFFF_0000;
      host_model_inst.read_seq(ADDR_RATIO_BYTE0 + 8'h01, 3);
      `CHK({rb(2), rb(1), rb(0)}, 24'h12_3456)
      host_model_inst.read_seq(ADDR_RATIO_BYTE0, 4);
      `CHK({rb(3), rb(2), rb(1), rb(0)}, 32'hFFFF_0000)
      rate = host_model_inst.rate_of({rb(3), rb(2), rb(1), rb(0)},
                                     32'h05F5_E100);
      `CHK(rate, 64'h0000_0000_05F5_DB0A)
      host_model_inst.read_seq(ADDR_STATUS_BYTE0, 25);
      for (int k = 0; k < 24; k++) `CHK(rb(k), stat[8*k +: 8])
      `CHK(rb(24), UNMAPPED_BYTE)
      host_model_inst.write_seq(ADDR_IDENTITY_AND_STATUS, 8'hFF);
      host_model_inst.write_seq(ADDR_RATIO_BYTE3, 8'h00);
      host_model_inst.read_seq(ADDR_IDENTITY_AND_STATUS, 1);
      `CHK(rb(0), {PID, 2'h3})
      host_model_inst.read_seq(ADDR_RATIO_BYTE3, 1);
      `CHK(rb(0), 8'hFF)
      `CHK(host_model_inst.nack_seen, 1'b0)
      `CHK(sdo, 1'b0)
      summarize();
   end
endmodule

`default_nettype wire
